// >>> rtl/ocf_pkg.sv
package ocf_pkg;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
   localparam logic [7:0] CMD_OC_RESP = 8'h47;
   localparam logic [7:0] CMD_UNIT_TIME = 8'hd2;
   // ----------------------------------------
   // Reset values and field positions
   // ----------------------------------------
   localparam logic [15:0] OC_LIMIT_RST = 16'h0000;
   localparam logic [7:0] OC_RESP_RST = 8'h00;
   localparam logic [15:0] UNIT_TIME_RST = 16'h0001;
   localparam int RESP_HI = 7;
   localparam int RESP_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // ----------------------------------------
   // Response codes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      OCF_IGNORE = 2'b00,
      OCF_COND_CC = 2'b01,
      OCF_SHUTDOWN = 2'b10,
      OCF_DELAY_CC = 2'b11
   } ocf_resp_t;
   typedef enum logic [2:0] {
      OCF_ST_RUN = 3'b000,
      OCF_ST_LIMIT = 3'b001,
      OCF_ST_OFF = 3'b010,
      OCF_ST_RESTART = 3'b011,
      OCF_ST_LATCHED = 3'b100
   } ocf_state_t;
endpackage

// >>> rtl/ocf_top.sv
// Contract
// - Retry code 111 restarts without count limit.
// - Delay code n selects 2^n time units.
// - Time unit length comes from register 0xd2.
// - Delay sets operating time after a fault.
// - Delay sets spacing between restart attempts.
// - Overcurrent limit is 16-bit read/write word.
// - Response configuration is read/write byte.
// - Any response code sets fault, notifies host.
// - Code 00 keeps running with current limit.
// - Code 01 limits while voltage above threshold.
// - Code 01 under threshold: shut down, retry.
// - Retry codes 000 to 110 count attempts.
// - Code 11 limits for delay, then retries.
// - Bit clear, clear-all or off/on clears latch.
`timescale 1ns/1ps
`default_nettype none
module ocf_top
   import ocf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic [15:0] cmd_rdata_ff,
   output logic cmd_ack_ff,
   input wire logic oc_detect,
   input wire logic vout_below_lv,
   input wire logic output_on_cmd,
   input wire logic clear_faults,
   input wire logic clear_oc_bit,
   input wire logic other_fault,
   output logic oc_fault_ff,
   output logic host_notify_ff,
   output logic output_en_ff,
   output logic current_limit_ff,
   output logic [15:0] oc_limit_out_ff
);
   import ocf_pkg::*;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Decoded delay length in units, used at fault and at each restart.
   function automatic logic [7:0] units_of(input logic [7:0] cfg);
      units_of = 8'h01 << cfg[DELAY_HI:DELAY_LO];
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] unit_time_ff;
   logic [7:0] oc_resp_ff;
   ocf_state_t state_ff;
   logic [15:0] tick_cnt_ff;
   logic [7:0] unit_cnt_ff;
   logic [2:0] tries_ff;
   logic on_prev_ff;
   logic delay_done;
   logic delay_restart;
   logic cycled_off;
   logic [2:0] retry_code;
   ocf_resp_t resp_code;

   assign retry_code = oc_resp_ff[RETRY_HI:RETRY_LO];
   assign resp_code = ocf_resp_t'(oc_resp_ff[RESP_HI:RESP_LO]);
   // An off command, a clear-all or a bit clear all release the latch.
   assign cycled_off = !output_on_cmd || clear_faults || clear_oc_bit;

   // Host writes; word for the limit, byte for the response.
   always_ff @(posedge clock) begin
      if (rst) begin
         oc_limit_out_ff <= OC_LIMIT_RST;
         oc_resp_ff <= OC_RESP_RST;
         unit_time_ff <= UNIT_TIME_RST;
      end else if (clk_en && cmd_wr) begin
         if (cmd_code == CMD_OC_LIMIT) begin
            oc_limit_out_ff <= cmd_wdata;
         end else if (cmd_code == CMD_OC_RESP) begin
            oc_resp_ff <= cmd_wdata[7:0];
         end else if (cmd_code == CMD_UNIT_TIME) begin
            unit_time_ff <= cmd_wdata;
         end
      end
   end

   // Host reads answer one cycle later; unknown codes read as zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_rdata_ff <= 16'h0000;
         cmd_ack_ff <= 1'b0;
      end else if (clk_en) begin
         cmd_ack_ff <= cmd_rd || cmd_wr;
         if (!cmd_rd) begin
            cmd_rdata_ff <= cmd_rdata_ff;
         end else if (cmd_code == CMD_OC_LIMIT) begin
            cmd_rdata_ff <= oc_limit_out_ff;
         end else if (cmd_code == CMD_OC_RESP) begin
            cmd_rdata_ff <= {8'h00, oc_resp_ff};
         end else if (cmd_code == CMD_UNIT_TIME) begin
            cmd_rdata_ff <= unit_time_ff;
         end else begin
            cmd_rdata_ff <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // Delay timer
   // ----------------------------------------
   // Ticks count clocks per unit; units count to the decoded length.
   // The timer only runs in the limit and restart states.
   assign delay_done = (unit_cnt_ff == units_of(oc_resp_ff));
   assign delay_restart = !(state_ff == OCF_ST_LIMIT ||
                            state_ff == OCF_ST_RESTART);
   always_ff @(posedge clock) begin
      if (rst) begin
         tick_cnt_ff <= 16'h0000;
         unit_cnt_ff <= 8'h00;
      end else if (clk_en) begin
         if (delay_restart || delay_done) begin
            tick_cnt_ff <= 16'h0000;
            unit_cnt_ff <= 8'h00;
         end else if (tick_cnt_ff + 16'h0001 >= unit_time_ff) begin
            tick_cnt_ff <= 16'h0000;
            unit_cnt_ff <= unit_cnt_ff + 8'h01;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Fault response state machine
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= OCF_ST_RUN;
         tries_ff <= 3'h0;
      end else if (clk_en) begin
         case (state_ff)
            OCF_ST_RUN: begin
               tries_ff <= 3'h0;
               if (oc_detect && resp_code == OCF_SHUTDOWN) begin
                  state_ff <= OCF_ST_OFF;
               end else if (oc_detect) begin
                  state_ff <= OCF_ST_LIMIT;
               end
            end
            OCF_ST_LIMIT: begin
               if (other_fault) begin
                  state_ff <= OCF_ST_LATCHED;
               end else if (!oc_detect) begin
                  state_ff <= OCF_ST_RUN;
               end else if (resp_code == OCF_COND_CC && vout_below_lv) begin
                  state_ff <= OCF_ST_OFF;
               end else if (resp_code == OCF_DELAY_CC && delay_done) begin
                  state_ff <= OCF_ST_OFF;
               end else if (resp_code == OCF_SHUTDOWN) begin
                  state_ff <= OCF_ST_OFF;
               end
            end
            OCF_ST_OFF: begin
               if (retry_code == RETRY_NONE || other_fault ||
                   (retry_code != RETRY_FOREVER && tries_ff >= retry_code)) begin
                  state_ff <= OCF_ST_LATCHED;
               end else begin
                  state_ff <= OCF_ST_RESTART;
                  if (retry_code != RETRY_FOREVER) begin
                     tries_ff <= tries_ff + 3'h1;
                  end
               end
            end
            OCF_ST_RESTART: begin
               if (!output_on_cmd || other_fault) begin
                  state_ff <= OCF_ST_LATCHED;
               end else if (delay_done && oc_detect) begin
                  state_ff <= OCF_ST_LIMIT;
               end else if (delay_done) begin
                  // A fault gone during the wait means the restart held.
                  state_ff <= OCF_ST_RUN;
               end
            end
            OCF_ST_LATCHED: begin
               if (cycled_off) begin
                  state_ff <= OCF_ST_RUN;
               end
            end
            default: begin
               state_ff <= OCF_ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Status and outputs
   // ----------------------------------------
   // The fault bit is sticky; a new detection wins over a clear.
   always_ff @(posedge clock) begin
      if (rst) begin
         oc_fault_ff <= 1'b0;
         host_notify_ff <= 1'b0;
         // Seen as on at reset, so a steady on command gives no false edge.
         on_prev_ff <= 1'b1;
      end else if (clk_en) begin
         on_prev_ff <= output_on_cmd;
         host_notify_ff <= oc_detect && !oc_fault_ff;
         if (oc_detect) begin
            oc_fault_ff <= 1'b1;
         end else if (clear_faults || clear_oc_bit ||
                      (output_on_cmd && !on_prev_ff)) begin
            oc_fault_ff <= 1'b0;
         end
      end
   end

   // The output is enabled only when commanded on and not shut down.
   always_ff @(posedge clock) begin
      if (rst) begin
         output_en_ff <= 1'b0;
         current_limit_ff <= 1'b0;
      end else if (clk_en) begin
         output_en_ff <= output_on_cmd &&
                         (state_ff == OCF_ST_RUN ||
                          state_ff == OCF_ST_LIMIT);
         current_limit_ff <= (state_ff == OCF_ST_LIMIT);
      end
   end
endmodule
`default_nettype wire

// >>> testbench/ocf_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checker
// ------
module ocf_monitor
   import ocf_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic oc_detect,
   input wire logic output_on_cmd,
   input wire logic [15:0] cmd_rdata_ff,
   input wire logic cmd_ack_ff,
   input wire logic oc_fault_ff,
   input wire logic host_notify_ff,
   input wire logic output_en_ff,
   input wire logic current_limit_ff
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // A request only counts when the clock enable lets it in.
   sequence s_req;
      (cmd_wr || cmd_rd) && clk_en;
   endsequence
   sequence s_rd(c);
      cmd_rd && clk_en && cmd_code == c;
   endsequence
   ack_follows_a:
   assert property (s_req |=> cmd_ack_ff) else $error("ack missing");
   ack_cause_a:
   assert property ($rose(cmd_ack_ff) |-> $past(cmd_wr) || $past(cmd_rd))
      else $error("ack without request");
   byte_read_a:
   assert property (s_rd(CMD_OC_RESP) |=> cmd_rdata_ff[15:8] == 8'h00)
      else $error("byte read upper byte set");
   unknown_read_a:
   assert property (s_rd(8'h48) |=> cmd_rdata_ff == 16'h0000)
      else $error("unknown read not zero");
   fault_set_a:
   assert property (oc_detect && clk_en |=> oc_fault_ff)
      else $error("fault bit not set");
   notify_a:
   assert property ($rose(oc_fault_ff) |-> ##[0:1] host_notify_ff)
      else $error("host not notified");
   notify_pulse_a:
   assert property (host_notify_ff && clk_en |=> !host_notify_ff)
      else $error("notify longer than a cycle");
   limit_cause_a:
   assert property ($rose(current_limit_ff) |-> $past(oc_detect, 2))
      else $error("limit without overcurrent");
   enable_cause_a:
   assert property ($rose(output_en_ff) |-> $past(output_on_cmd))
      else $error("output on without command");
endmodule
bind ocf_top ocf_monitor ocf_monitor_inst (.clock(clock), .rst(rst),
   .clk_en(clk_en), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
   .cmd_code(cmd_code), .oc_detect(oc_detect),
   .output_on_cmd(output_on_cmd), .cmd_rdata_ff(cmd_rdata_ff),
   .cmd_ack_ff(cmd_ack_ff), .oc_fault_ff(oc_fault_ff),
   .host_notify_ff(host_notify_ff), .output_en_ff(output_en_ff),
   .current_limit_ff(current_limit_ff));
`default_nettype wire

// >>> testbench/ocf_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Host model of the command port
// ------
module ocf_host (
   input wire logic clock,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata_ff,
   input wire logic cmd_ack_ff
);
   // Idle lines start low.
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // word and byte transfers
   // Released code and data lines show the inverse so stale values never look valid.
   task automatic xfer(input logic wr, input logic [7:0] code,
         input logic [15:0] wd, output logic [16:0] res);
      @(negedge clock);
      cmd_wr = wr;
      cmd_rd = !wr;
      cmd_code = code;
      cmd_wdata = wd;
      @(negedge clock);
      res = {cmd_ack_ff, cmd_rdata_ff};
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = ~code;
      cmd_wdata = ~wd;
   endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ocf_pkg::*;
   logic clock, rst, clk_en, oc_detect, vout_below_lv, output_on_cmd;
   logic clear_faults, clear_oc_bit, other_fault, cmd_wr, cmd_rd;
   logic cmd_ack_ff, oc_fault_ff, host_notify_ff, output_en_ff;
   logic current_limit_ff;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata_ff, oc_limit_out_ff;
   logic [16:0] res;
   logic [2:0] rc [3] = '{3'h1, 3'h6, 3'h7};
   int bad_count = 0;
   int total_checks = 0;
   int t0, t, n;
   ocf_top ocf_top_inst (.clock(clock), .rst(rst), .clk_en(clk_en),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_rdata_ff(cmd_rdata_ff),
      .cmd_ack_ff(cmd_ack_ff), .oc_detect(oc_detect),
      .vout_below_lv(vout_below_lv), .output_on_cmd(output_on_cmd),
      .clear_faults(clear_faults), .clear_oc_bit(clear_oc_bit),
      .other_fault(other_fault), .oc_fault_ff(oc_fault_ff),
      .host_notify_ff(host_notify_ff), .output_en_ff(output_en_ff),
      .current_limit_ff(current_limit_ff),
      .oc_limit_out_ff(oc_limit_out_ff));
   ocf_host ocf_host_inst (.clock(clock), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_rdata_ff(cmd_rdata_ff), .cmd_ack_ff(cmd_ack_ff));
   // Free running clock at 40 ns.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic check(input string what, input logic [16:0] seen,
         input logic [16:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      ocf_host_inst.xfer(1'b0, c, 16'h0000, res);
      check("read", res, {1'b1, e});
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      ocf_host_inst.xfer(1'b1, c, d, res);
      check("write ack", {16'h0, res[16]}, 17'h1);
   endtask
   // Holds the overcurrent until the output drops or 3000 cycles pass, counting cycles.
   task automatic trip(input logic [7:0] resp, output int cyc);
      wr(CMD_OC_RESP, {8'h00, resp});
      cyc = 0;
      oc_detect = 1'b1;
      while (output_en_ff === 1'b1 && cyc < 3000) begin
         @(negedge clock);
         cyc++;
      end
      oc_detect = 1'b0;
   endtask
   task automatic clr(input logic bit_only);
      clear_oc_bit = bit_only;
      clear_faults = !bit_only;
      @(negedge clock);
      clear_oc_bit = 1'b0;
      clear_faults = 1'b0;
      repeat (4) @(negedge clock);
      check("fault cleared", {16'h0, oc_fault_ff}, 17'h0);
   endtask
   task automatic rises(input int cyc, output int cnt);
      logic last;
      cnt = 0;
      last = output_en_ff;
      repeat (cyc) begin
         @(negedge clock);
         if (output_en_ff === 1'b1 && last !== 1'b1) cnt++;
         last = output_en_ff;
      end
   endtask
   // Watchdog well beyond the expected run length.
   initial begin
      #1000000;
      bad_count++;
      complete_run();
   end
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      oc_detect = 1'b0;
      vout_below_lv = 1'b0;
      output_on_cmd = 1'b1;
      clear_faults = 1'b0;
      clear_oc_bit = 1'b0;
      other_fault = 1'b0;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      rd(CMD_OC_LIMIT, OC_LIMIT_RST);
      rd(CMD_OC_RESP, OC_RESP_RST);
      rd(CMD_UNIT_TIME, UNIT_TIME_RST);
      wr(CMD_OC_LIMIT, 16'hbeef);
      rd(CMD_OC_LIMIT, 16'hbeef);
      check("limit out", {1'b0, oc_limit_out_ff}, 17'h0beef);
      // A frozen block neither answers nor takes a write.
      @(negedge clock);
      clk_en = 1'b0;
      ocf_host_inst.xfer(1'b1, CMD_OC_LIMIT, 16'h1111, res);
      check("frozen ack", {16'h0, res[16]}, 17'h0);
      clk_en = 1'b1;
      rd(CMD_OC_LIMIT, 16'hbeef);
      wr(CMD_OC_RESP, 16'hff5a);
      rd(CMD_OC_RESP, 16'h005a);
      wr(8'h48, 16'h1234);
      rd(8'h48, 16'h0000);
      wr(CMD_UNIT_TIME, 16'h0003);
      // Delay codes 0 to 3 each add a power of two of three-clock units.
      for (int k = 0; k < 4; k++) begin
         trip({5'b11000, 3'(k)}, t);
         if (k == 0) t0 = t;
         check("delay", 17'(t - t0), 17'(3 * ((1 << k) - 1)));
         check("fault bit", {16'h0, oc_fault_ff}, 17'h1);
         rises(40, n);
         check("latched", 17'(n), 17'h0);
         clr(k[0]);
      end
      trip(8'h00, t);
      check("brickwall", 17'(t), 17'd3000);
      check("limiting", {16'h0, current_limit_ff}, 17'h1);
      clr(1'b0);
      trip(8'h40, t);
      check("cond limit", 17'(t), 17'd3000);
      clr(1'b0);
      // Code 10 drops the output at once and stays off with no retry.
      trip(8'h80, t);
      check("shutdown", 17'(t), 17'd2);
      clr(1'b1);
      // Low voltage under limiting shuts down and retries; 7 = forever.
      foreach (rc[i]) begin
         wr(CMD_OC_RESP, {8'h00, 2'b01, rc[i], 3'b000});
         oc_detect = 1'b1;
         vout_below_lv = 1'b1;
         rises(400, n);
         check("retries", 17'(n > 6 ? 7 : n), {14'h0, rc[i]});
         output_on_cmd = 1'b0;
         rises(50, n);
         check("off stops", 17'(n), 17'h0);
         oc_detect = 1'b0;
         vout_below_lv = 1'b0;
         output_on_cmd = 1'b1;
         clr(1'b0);
      end
      // Another fault stops even endless retries.
      wr(CMD_OC_RESP, {8'h00, 2'b01, RETRY_FOREVER, 3'b000});
      other_fault = 1'b1;
      oc_detect = 1'b1;
      vout_below_lv = 1'b1;
      rises(100, n);
      check("other fault", 17'(n), 17'h0);
      other_fault = 1'b0;
      oc_detect = 1'b0;
      vout_below_lv = 1'b0;
      clr(1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
